// File: core/wlsp_flash_end.sv
// flash end: write enable latch and per-sector protect bits
// it decodes enable, disable, protect and unprotect frames off the serial link
// assumes link pins are asynchronous to clk and slower than clk / 6
// assumes lock bit, mode flag and access address come from logic on clk
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wlsp_map.svh"

module wlsp_flash_end
  import wlsp_pkg::*;
(
  input  wire logic        clk,               // system clock, 25 MHz
  input  wire logic        rst_n,             // synchronous reset, low
  wlsp_if.flash            link,              // serial link from host
  input  wire logic        protectionLockBit, // lock from status register
  input  wire logic        seqProgramActive,  // sequential program mode on
  input  wire logic [23:0] accessAddr,        // address of program/erase
  output logic             writeEnableLatch,  // latch state
  output logic [15:0]      sectorProtect,     // one bit per sector, 1 = locked
  output logic             seqProgramExit,    // one-cycle pulse, leave mode
  output logic             accessPermit       // program/erase allowed at accessAddr
);

  // ==========================================================
  // pin synchronisers
  logic [2:0] csPipe;
  logic [2:0] sclkPipe;
  logic [1:0] mosiPipe;
  logic       csFall;
  logic       csRise;
  logic       sclkRise;
  logic       bitIn;

  // two flops per pin; third stage only feeds edge detection
  // reset values match the idle pins, so no false edge follows reset
  // cost: every link event is seen two clk late, hence the slow-link limit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      csPipe   <= 3'h7;
      sclkPipe <= 3'h0;
      mosiPipe <= 2'h0;
    end else begin
      csPipe   <= {csPipe[1:0], link.csN};
      sclkPipe <= {sclkPipe[1:0], link.sclk};
      mosiPipe <= {mosiPipe[0], link.mosi};
    end
  end

  // edges from stage two against stage three; sclk counts only inside a frame
  assign csFall   = csPipe[2] & ~csPipe[1];
  assign csRise   = ~csPipe[2] & csPipe[1];
  assign sclkRise = ~sclkPipe[2] & sclkPipe[1] & ~csPipe[1];
  assign bitIn    = mosiPipe[1];

  // ==========================================================
  // command decoder
  // it only follows select and sclk rises; nothing here drives the link
  wlsp_dev_state_t state;
  wlsp_dev_state_t next_state;
  logic [2:0]      bitInByte;
  logic [2:0]      byteCount;
  logic [7:0]      opcode;
  logic [7:0]      next_opcode;
  logic [23:0]     address;
  logic            byteDone;
  logic            isSectorCmd;

  assign next_opcode = {opcode[6:0], bitIn};
  assign byteDone    = sclkRise && (bitInByte == 3'h7);
  assign isSectorCmd = (next_opcode == `WLSP_OP_PROTECT) ||
                       (next_opcode == `WLSP_OP_UNPROTECT);

  // next state: decode restarts on every select fall
  always_comb begin
    next_state = state;
    case (state)
      DEV_IDLE: begin
        if (csFall) next_state = DEV_OPCODE;
      end
      DEV_OPCODE: begin
        if (csRise) next_state = DEV_IDLE;
        else if (byteDone) next_state = isSectorCmd ? DEV_ADDR : DEV_TAIL;
      end
      DEV_ADDR: begin
        if (csRise) next_state = DEV_IDLE;
        else if (byteDone && byteCount == `WLSP_ADDR_BYTES) next_state = DEV_TAIL;
      end
      DEV_TAIL: begin
        if (csRise) next_state = DEV_IDLE;
      end
      default: next_state = DEV_IDLE;
    endcase
    // a select fall always restarts decode, whatever state was left behind
    if (csFall) next_state = DEV_OPCODE;
  end

  // state register
  // an illegal code falls back to idle through the default branch
  always_ff @(posedge clk) begin
    if (!rst_n) state <= DEV_IDLE;
    else        state <= next_state;
  end

  // bit and byte counters; byte count saturates past the address
  // four means the whole address is in; a long tail cannot wrap back to it
  always_ff @(posedge clk) begin
    if (!rst_n || csFall) begin
      bitInByte <= 3'h0;
      byteCount <= 3'h0;
    end else if (sclkRise && state != DEV_IDLE) begin
      bitInByte <= bitInByte + 3'h1;
      if (bitInByte == 3'h7 && byteCount != 3'h4) byteCount <= byteCount + 3'h1;
    end
  end

  // opcode and address shifters, msb first; tail bits are dropped
  // tail bits must never reach the opcode, or a long frame would change the command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opcode  <= 8'h00;
      address <= 24'h000000;
    end else if (csFall) begin
      opcode  <= 8'h00;
      address <= 24'h000000;
    end else if (sclkRise && state == DEV_OPCODE) begin
      opcode  <= next_opcode;
    end else if (sclkRise && state == DEV_ADDR) begin
      address <= {address[22:0], bitIn};
    end
  end

  // ==========================================================
  // execution at select rise
  // outcome at frame end, by opcode:
  //   enable, whole frame          -> latch set
  //   disable, whole frame         -> latch cleared, mode exit if active
  //   enable/disable, cut frame    -> nothing
  //   protect/unprotect, latch low -> nothing
  //   protect/unprotect, latch set -> latch cleared; bit written only for
  //                                   a whole address with the lock off
  //   any other opcode             -> nothing
  logic       frameEnd;
  logic       aligned;
  logic       opcodeWhole;
  logic       addrWhole;
  logic       sectorCmd;
  logic [3:0] targetSector;
  logic       wrenDone;
  logic       wrdisDone;
  logic       sectorEnd;
  logic       protWrite;

  // a partly shifted opcode can mimic a sector opcode, so a whole byte is needed
  assign frameEnd     = csRise && state != DEV_IDLE;
  assign aligned      = (bitInByte == 3'h0);
  assign opcodeWhole  = (byteCount != 3'h0) && aligned;
  assign addrWhole    = (byteCount == 3'h4) && aligned;
  assign sectorCmd    = (byteCount != 3'h0) &&
                        ((opcode == `WLSP_OP_PROTECT) || (opcode == `WLSP_OP_UNPROTECT));
  // sector index from the full address; bits above the array wrap
  assign targetSector = address[`WLSP_SECT_MSB:`WLSP_SECT_LSB];

  // decisions taken at the frame end, one per outcome
  assign wrenDone     = frameEnd && opcodeWhole && (opcode == `WLSP_OP_WREN);
  assign wrdisDone    = frameEnd && opcodeWhole && (opcode == `WLSP_OP_WRDIS);
  assign sectorEnd    = frameEnd && sectorCmd;
  // the lock freezes every bit; only a status write, outside, can free it
  assign protWrite    = sectorEnd && writeEnableLatch && addrWhole &&
                        !protectionLockBit;

  // latch: enable and disable act only on a whole, aligned frame; a sector frame always clears it
  // a cut enable or disable frame leaves the latch alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      writeEnableLatch <= 1'b0;
    end else if (wrenDone) begin
      writeEnableLatch <= 1'b1;
    end else if (wrdisDone) begin
      writeEnableLatch <= 1'b0;
    end else if (sectorEnd) begin
      // done, aborted or locked: the latch always drops
      writeEnableLatch <= 1'b0;
    end
  end

  // protect bits: all protected after reset, lock freezes them
  // only the addressed bit is written; its neighbours keep their value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sectorProtect <= `WLSP_PROT_RESET;
    end else if (protWrite) begin
      sectorProtect[targetSector] <= (opcode == `WLSP_OP_PROTECT);
    end
  end

  // disable frame ends sequential program mode, one pulse
  // registered, so it rises at the same edge as the latch falls
  always_ff @(posedge clk) begin
    if (!rst_n) seqProgramExit <= 1'b0;
    else        seqProgramExit <= wrdisDone && seqProgramActive;
  end

  // gate for program and erase engines; combinational on purpose so
  // the engine sees the permit in the same cycle it presents the address
  assign accessPermit = writeEnableLatch &&
                        !sectorProtect[accessAddr[`WLSP_SECT_MSB:`WLSP_SECT_LSB]];

endmodule

`default_nettype wire

// File: core/wlsp_host_end.sv
// host end: APB-programmed controller that sends one framed command
// assumes APB master on clk; sclk is made here by dividing clk
`timescale 1ns/1ps
`default_nettype none
`include "wlsp_map.svh"

module wlsp_host_end
  import wlsp_pkg::*;
(
  input  wire logic        clk,     // system clock, 25 MHz
  input  wire logic        rst_n,   // synchronous reset, low
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB access phase
  input  wire logic        pwrite,  // APB write
  input  wire logic [7:0]  paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic [31:0]      prdata,  // APB read data
  output logic             pready,  // APB ready, always high
  output logic             pslverr, // APB error on unmapped address
  wlsp_if.host             link     // serial link to flash
);

  // ==========================================================
  // register bus
  logic [7:0]  cmdOpcode;
  logic [5:0]  cmdBits;
  logic [23:0] cmdAddr;
  logic        busy;
  logic        wrStb;
  logic        goStb;
  logic        mapped;

  assign mapped  = (paddr == `WLSP_REG_CTRL) || (paddr == `WLSP_REG_CMD) ||
                   (paddr == `WLSP_REG_ADDR) || (paddr == `WLSP_REG_STAT);
  assign pready  = 1'b1;                         // zero wait states
  assign pslverr = psel && penable && !mapped;
  assign wrStb   = psel && penable && pwrite && mapped;
  assign goStb   = wrStb && paddr == `WLSP_REG_CTRL && pwdata[`WLSP_CTRL_GO] && !busy;

  // command registers; the frame runs from copies taken at go, yet writes while busy are refused
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmdOpcode <= 8'h00;
      cmdBits   <= 6'h00;
      cmdAddr   <= 24'h000000;
    end else if (wrStb && !busy) begin
      if (paddr == `WLSP_REG_CMD) begin
        cmdOpcode <= pwdata[`WLSP_CMD_OP_LSB +: 8];
        cmdBits   <= pwdata[`WLSP_CMD_BITS_LSB +: 6];
      end
      if (paddr == `WLSP_REG_ADDR) cmdAddr <= pwdata[23:0];
    end
  end

  // read data prepared in the setup cycle, held through access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `WLSP_REG_CMD:  prdata <= {18'h0, cmdBits, cmdOpcode};
        `WLSP_REG_ADDR: prdata <= {8'h00, cmdAddr};
        `WLSP_REG_STAT: prdata <= {31'h0, busy};
        default:        prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // frame sequencer, spi mode 0
  wlsp_host_state_t state;
  logic [3:0]       divCnt;
  logic [5:0]       bitsLeft;
  logic [31:0]      shiftOut;
  logic             halfDone;

  assign halfDone = (divCnt == `WLSP_SCLK_HALF - 4'h1);

  // sequencer with pins; data changes only while sclk is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= HST_IDLE;
      busy      <= 1'b0;
      divCnt    <= 4'h0;
      bitsLeft  <= 6'h00;
      shiftOut  <= 32'h00000000;
      link.csN  <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
    end else begin
      divCnt <= halfDone ? 4'h0 : divCnt + 4'h1;
      case (state)
        HST_IDLE: begin
          divCnt <= 4'h0;
          if (goStb) begin
            busy      <= 1'b1;
            state     <= HST_LEAD;
            bitsLeft  <= cmdBits;
            shiftOut  <= {cmdOpcode, cmdAddr};
            link.csN  <= 1'b0;
            link.mosi <= cmdOpcode[7];
          end
        end
        HST_LEAD: begin
          if (halfDone) begin
            if (bitsLeft == 6'h00) begin
              state <= HST_TRAIL;
            end else begin
              link.sclk <= 1'b1;
              state     <= HST_HIGH;
            end
          end
        end
        HST_LOW: begin
          if (halfDone) begin
            link.sclk <= 1'b1;
            state     <= HST_HIGH;
          end
        end
        HST_HIGH: begin
          if (halfDone) begin
            link.sclk <= 1'b0;
            link.mosi <= shiftOut[30];                  // msb first
            shiftOut  <= {shiftOut[30:0], 1'b0};        // beyond 32 bits sends zeros
            bitsLeft  <= bitsLeft - 6'h01;
            state     <= (bitsLeft == 6'h01) ? HST_TRAIL : HST_LOW;
          end
        end
        HST_TRAIL: begin
          if (halfDone) begin
            link.csN <= 1'b1;
            state    <= HST_GAP;
          end
        end
        HST_GAP: begin
          // deselect time so the flash sees the frame end before the next
          if (divCnt == `WLSP_CS_GAP - 4'h1) begin
            busy  <= 1'b0;
            state <= HST_IDLE;
          end else begin
            divCnt <= divCnt + 4'h1;
          end
        end
        default: state <= HST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: core/wlsp_if.sv
// serial link between host controller and flash command logic
// assumes host drives all three wires; nothing is two-way
`timescale 1ns/1ps
`default_nettype none

interface wlsp_if;
  logic csN;   // chip select, low during a frame
  logic sclk;  // serial clock made by the host
  logic mosi;  // serial data host to flash

  modport flash (input csN, input sclk, input mosi);
  modport host  (output csN, output sclk, output mosi);
endinterface

`default_nettype wire

// File: core/wlsp_map.svh
// offsets, opcodes, field positions and timing counts shared by both ends
// assumes the includer sits in core/ and has the package compiled first
//
// Notes on behaviour
// - latch must be set before protect/unprotect execute
// - opcode 06h sets latch at frame end
// - opcode 04h clears latch at frame end
// - short or unaligned enable/disable frame leaves latch untouched
// - bytes after enable/disable opcode are ignored
// - completed disable also ends sequential program mode
// - one protect bit per sector, 1 blocks
// - reset sets every protect bit to one
// - opcode 36h plus address protects that sector
// - opcode 39h plus address unprotects that sector
// - any address within sector selects it
// - short/unaligned protect frame keeps bit, clears latch
// - bytes after third address byte are ignored
// - lock bit set: ignore protect, clear latch
// - protected sector forbids program and erase access
// - lock bit only changed by status write
`ifndef WLSP_MAP_SVH
`define WLSP_MAP_SVH

// ==========================================================
// command opcodes
`define WLSP_OP_WREN      8'h06
`define WLSP_OP_WRDIS     8'h04
`define WLSP_OP_PROTECT   8'h36
`define WLSP_OP_UNPROTECT 8'h39

// ==========================================================
// array geometry: sixteen 64 Kbyte sectors
`define WLSP_SECTORS      16
`define WLSP_SECT_MSB     19
`define WLSP_SECT_LSB     16
`define WLSP_ADDR_BYTES   3'h3
`define WLSP_PROT_RESET   16'hFFFF

// ==========================================================
// host register map (APB byte offsets)
`define WLSP_REG_CTRL     8'h00
`define WLSP_REG_CMD      8'h04
`define WLSP_REG_ADDR     8'h08
`define WLSP_REG_STAT     8'h0C
`define WLSP_CTRL_GO      0
`define WLSP_CMD_OP_LSB   0
`define WLSP_CMD_BITS_LSB 8
`define WLSP_STAT_BUSY    0

// ==========================================================
// host serial timing, in clk cycles
`define WLSP_SCLK_HALF    4'h4
`define WLSP_CS_GAP       4'h8

`endif

// File: core/wlsp_pkg.sv
// types shared by the two ends of the protection command link
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package wlsp_pkg;

  // device command decoder states, one-hot
  typedef enum logic [3:0] {
    DEV_IDLE   = 4'h1,
    DEV_OPCODE = 4'h2,
    DEV_ADDR   = 4'h4,
    DEV_TAIL   = 4'h8
  } wlsp_dev_state_t;

  // host frame sequencer states, one-hot
  typedef enum logic [5:0] {
    HST_IDLE  = 6'h01,
    HST_LEAD  = 6'h02,
    HST_LOW   = 6'h04,
    HST_HIGH  = 6'h08,
    HST_TRAIL = 6'h10,
    HST_GAP   = 6'h20
  } wlsp_host_state_t;

endpackage

`default_nettype wire

// File: sim/tb.sv
// testbench: host end drives flash end over the link, orders come over APB
// assumes the core package, header and interface are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "wlsp_map.svh"

module tb;
  import wlsp_pkg::*;
  typedef struct packed {
    logic [7:0] op; logic [23:0] addr; logic [5:0] bits;
    logic lock, seq, lat, ext; logic [15:0] prot;
  } wlsp_row_t;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lockBit = 1'b0;
  logic        seqActive = 1'b0;
  logic [23:0] accessAddr = 24'h0;
  logic        writeEnableLatch;
  logic [15:0] sectorProtect;
  logic        seqProgramExit;
  logic        accessPermit;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          exitCnt = 0;
  int          exitBase;
  logic [31:0] q;
  logic        e;
  wlsp_row_t   rows [17];

  // ==========================================================
  // clock, design and checker
  always #20 clk = ~clk;
  always @(posedge clk) if (seqProgramExit === 1'b1) exitCnt <= exitCnt + 1;
  wlsp_if wlsp_if_i ();
  wlsp_host_end wlsp_host_end_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(wlsp_if_i));
  wlsp_flash_end wlsp_flash_end_i (.clk(clk), .rst_n(rst_n), .link(wlsp_if_i),
    .protectionLockBit(lockBit), .seqProgramActive(seqActive), .accessAddr(accessAddr),
    .writeEnableLatch(writeEnableLatch), .sectorProtect(sectorProtect),
    .seqProgramExit(seqProgramExit), .accessPermit(accessPermit));
  wlsp_link_props wlsp_link_props_i (.clk(clk), .rst_n(rst_n), .csN(wlsp_if_i.csN),
    .sclk(wlsp_if_i.sclk), .mosi(wlsp_if_i.mosi), .protectionLockBit(lockBit),
    .accessAddr(accessAddr), .writeEnableLatch(writeEnableLatch),
    .sectorProtect(sectorProtect), .seqProgramExit(seqProgramExit),
    .accessPermit(accessPermit));

  // ==========================================================
  // helpers; every task starts and ends just after a rising edge
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // one APB transfer; an idle cycle follows so psel is never set twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  // program one frame, start it and poll busy until it is over
  task automatic send(input wlsp_row_t r);
    lockBit <= r.lock; seqActive <= r.seq; accessAddr <= r.addr;
    apb(1'b1, `WLSP_REG_CMD, {18'h0, r.bits, r.op}, q, e);
    apb(1'b1, `WLSP_REG_ADDR, {8'h00, r.addr}, q, e);
    apb(1'b1, `WLSP_REG_CTRL, 32'h1, q, e);
    q = 32'h1;
    while (q[`WLSP_STAT_BUSY] !== 1'b0) apb(1'b0, `WLSP_REG_STAT, 32'h0, q, e);
  endtask

  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // main sequence: op, addr, bits, lock, seq -> latch, exit, protect bits
  initial begin
    rows = '{
      '{8'h06, 24'h050000, 6'd8,  1'b0, 1'b0, 1'b1, 1'b0, 16'hFFFF},
      '{8'h39, 24'h050000, 6'd32, 1'b0, 1'b0, 1'b0, 1'b0, 16'hFFDF},
      '{8'h39, 24'h0A1234, 6'd32, 1'b0, 1'b0, 1'b0, 1'b0, 16'hFFDF},
      '{8'h06, 24'h050000, 6'd16, 1'b0, 1'b0, 1'b1, 1'b0, 16'hFFDF},
      '{8'h39, 24'hF7FFFF, 6'd40, 1'b0, 1'b0, 1'b0, 1'b0, 16'hFF5F},
      '{8'h06, 24'h050000, 6'd7,  1'b0, 1'b0, 1'b0, 1'b0, 16'hFF5F},
      '{8'h06, 24'h050000, 6'd8,  1'b0, 1'b0, 1'b1, 1'b0, 16'hFF5F},
      '{8'h04, 24'h050000, 6'd12, 1'b0, 1'b1, 1'b1, 1'b0, 16'hFF5F},
      '{8'h04, 24'h050000, 6'd8,  1'b0, 1'b1, 1'b0, 1'b1, 16'hFF5F},
      '{8'h06, 24'h050000, 6'd8,  1'b0, 1'b0, 1'b1, 1'b0, 16'hFF5F},
      '{8'h36, 24'h050000, 6'd24, 1'b0, 1'b0, 1'b0, 1'b0, 16'hFF5F},
      '{8'h06, 24'h050000, 6'd8,  1'b0, 1'b0, 1'b1, 1'b0, 16'hFF5F},
      '{8'h39, 24'h0F0000, 6'd31, 1'b0, 1'b0, 1'b0, 1'b0, 16'hFF5F},
      '{8'h06, 24'h050000, 6'd8,  1'b0, 1'b0, 1'b1, 1'b0, 16'hFF5F},
      '{8'h36, 24'h07ABCD, 6'd32, 1'b0, 1'b0, 1'b0, 1'b0, 16'hFFDF},
      '{8'h06, 24'h050000, 6'd8,  1'b1, 1'b0, 1'b1, 1'b0, 16'hFFDF},
      '{8'h36, 24'h050000, 6'd32, 1'b1, 1'b0, 1'b0, 1'b0, 16'hFFDF}};
    repeat (20) @(posedge clk);
    chk(sectorProtect === `WLSP_PROT_RESET, "protect bits after reset");
    chk(writeEnableLatch === 1'b0, "latch after reset");
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      exitBase = exitCnt;
      send(rows[i]);
      chk(writeEnableLatch === rows[i].lat, "latch");
      chk(sectorProtect === rows[i].prot, "protect bits");
      chk((exitCnt - exitBase) == int'(rows[i].ext), "mode exit count");
      chk(accessPermit === (rows[i].lat & ~rows[i].prot[rows[i].addr[19:16]]),
          "access gate");
    end
    // command registers read back as last written; control reads as zero
    apb(1'b0, `WLSP_REG_CMD, 32'h0, q, e);
    chk(q === 32'h00002036 && e === 1'b0, "command read back");
    apb(1'b0, `WLSP_REG_ADDR, 32'h0, q, e);
    chk(q === 32'h00050000, "address read back");
    apb(1'b0, `WLSP_REG_CTRL, 32'h0, q, e);
    chk(q === 32'h0, "control reads zero");
    // unmapped address is refused with an error and zero data
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk(e === 1'b1 && q === 32'h0, "unmapped read");
    // latch set, long frame started, then a command write while busy is refused
    send(rows[0]);
    apb(1'b1, `WLSP_REG_CMD, 32'h00002039, q, e);
    apb(1'b1, `WLSP_REG_CTRL, 32'h1, q, e);
    apb(1'b1, `WLSP_REG_CMD, 32'h00000804, q, e);
    apb(1'b0, `WLSP_REG_CMD, 32'h0, q, e);
    chk(q === 32'h00002039, "command written while busy");
    // reset in mid-frame drops the latch and protects every sector
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(sectorProtect === `WLSP_PROT_RESET && writeEnableLatch === 1'b0,
        "state after second reset");
    chk(wlsp_if_i.csN === 1'b1 && wlsp_if_i.sclk === 1'b0, "link idle after reset");
    // the link works at once after reset: no false edge from the cut frame
    send(rows[0]);
    chk(writeEnableLatch === 1'b1, "latch after second reset");
    finish_test();
  end
endmodule

`default_nettype wire

// File: sim/wlsp_link_props.sv
// concurrent checks on the serial link and the flash end results
// assumes one clk domain; the tb instantiates it beside the link interface
`timescale 1ns/1ps
`default_nettype none

module wlsp_link_props (
  input wire logic        clk,               // system clock
  input wire logic        rst_n,             // synchronous reset, low
  input wire logic        csN,               // link chip select
  input wire logic        sclk,              // link serial clock
  input wire logic        mosi,              // link data
  input wire logic        protectionLockBit, // lock input
  input wire logic [23:0] accessAddr,        // access address
  input wire logic        writeEnableLatch,  // latch state
  input wire logic [15:0] sectorProtect,     // protect bits
  input wire logic        seqProgramExit,    // mode exit pulse
  input wire logic        accessPermit       // access gate
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // latch only moves once the frame is over
  property p_latch_frame_end; $changed(writeEnableLatch) |-> csN; endproperty
  a_latch_frame_end: assert property (p_latch_frame_end) else $error("latch moved in frame");
  // a set comes right after a frame that ran at least eight clk back
  property p_latch_set; $rose(writeEnableLatch) |-> csN && !$past(csN, 8); endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch set without frame");
  property p_need_latch; $changed(sectorProtect) |-> $past(writeEnableLatch); endproperty
  a_need_latch: assert property (p_need_latch) else $error("protect write without latch");
  property p_clr_latch; $changed(sectorProtect) |-> !writeEnableLatch; endproperty
  a_clr_latch: assert property (p_clr_latch) else $error("latch kept after protect");
  // one sector per command, whatever low address bits were sent
  property p_one_sector;
    $changed(sectorProtect) |-> $onehot(sectorProtect ^ $past(sectorProtect));
  endproperty
  a_one_sector: assert property (p_one_sector) else $error("several sectors changed");
  property p_lock;
    protectionLockBit && $past(protectionLockBit) |-> $stable(sectorProtect);
  endproperty
  a_lock: assert property (p_lock) else $error("protect bits moved under lock");
  property p_permit;
    accessPermit == (writeEnableLatch && !sectorProtect[accessAddr[19:16]]);
  endproperty
  a_permit: assert property (p_permit) else $error("access gate wrong");
  property p_exit; seqProgramExit |-> csN && !writeEnableLatch ##1 !seqProgramExit; endproperty
  a_exit: assert property (p_exit) else $error("mode exit pulse wrong");
  // data holds across the high half of sclk, from the second high sample on
  property p_mosi; sclk && $past(sclk) && !csN |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi) else $error("mosi moved with sclk high");
  property p_sclk_idle; csN |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk runs while deselected");

  // ==========================================================
  // covers
  c_latch: cover property ($rose(writeEnableLatch));
  c_prot: cover property ($changed(sectorProtect));
  c_exit: cover property (seqProgramExit);
endmodule

`default_nettype wire
